// ==== include/tec16_consts.svh ====
`ifndef TEC16_CONSTS_SVH
`define TEC16_CONSTS_SVH

// Register byte addresses
`define TEC_ADR_CTL0 32'h0ffff590
`define TEC_ADR_CTL1 32'h0ffff594
`define TEC_ADR_OCFG 32'h0ffff598
`define TEC_ADR_ECFGA 32'h0ffff59c
`define TEC_ADR_ECFGB 32'h0ffff5a0
`define TEC_ADR_CCR0 32'h0ffff5a4
`define TEC_ADR_CCR1 32'h0ffff5a8
`define TEC_ADR_CNT 32'h0ffff5ac
`define TEC_ADR_STAT 32'h0ffff5b0

// Reset values
`define TEC_RST_BYTE 8'h00
`define TEC_RST_WORD 16'h0000
`define TEC_CNT_IDLE 16'hffff
`define TEC_CNT_ZERO 16'h0000
`define TEC_CNT_ONE 16'h0001

// Field positions and masks
`define TEC_CTL0_EN 7
`define TEC_CTL0_MASK 8'h87
`define TEC_CTL1_EST 6
`define TEC_CTL1_EEE 5
`define TEC_CTL1_MASK 8'h27
`define TEC_OCFG_MASK 8'h0f
`define TEC_ECFG_MASK 8'h0f
`define TEC_STAT_OVF 0
`define TEC_CKS_SUB 3'h7

// Prescaler width covers the longest division, main clock / 128
`define TEC_PRE_W 7

// AHB-Lite encodings
`define TEC_HSIZE_BYTE 3'h0
`define TEC_HSIZE_HALF 3'h1

`endif

// ==== include/tec16_pkg.sv ====
package tec16_pkg;

  // Operating modes in mode_select_field order
  typedef enum logic [2:0] {
    TEC16_MD_INTERVAL,
    TEC16_MD_EVENT,
    TEC16_MD_EXT_TRIG,
    TEC16_MD_ONE_SHOT,
    TEC16_MD_PWM,
    TEC16_MD_FREE_RUN,
    TEC16_MD_PULSE_WIDTH,
    TEC16_MD_PROHIBITED
  } tec16_mode_e;

  // Valid-edge selection of one edge detector
  typedef enum logic [1:0] {
    TEC16_EDGE_NONE,
    TEC16_EDGE_RISE,
    TEC16_EDGE_FALL,
    TEC16_EDGE_BOTH
  } tec16_edge_e;

  // channel_control_0 layout
  typedef struct packed {
    logic en;
    logic [3:0] rsvd;
    logic [2:0] cks;
  } tec16_ctl0_s;

  // Held AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] size;
    logic [31:0] addr;
  } tec16_aphase_s;

endpackage : tec16_pkg

// ==== rtl/tec16_timer.sv ====
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "tec16_consts.svh"
module tec16_timer
  import tec16_pkg::*;
#(
  parameter bit ODD_CHANNEL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer_input_0,
  input wire logic timer_input_1,
  input wire logic subclock_in,
  input wire logic main_clk_stopped,
  output logic timer_output_0,
  output logic timer_output_1,
  output logic match_irq_0,
  output logic match_irq_1
);

  // Edge qualifier from a two-bit configuration
  function automatic logic edge_hit(input logic [1:0] cfg,
                                    input logic rise,
                                    input logic fall);
    tec16_edge_e e;
    e = tec16_edge_e'(cfg);
    unique case (e)
      TEC16_EDGE_NONE: edge_hit = 1'b0;
      TEC16_EDGE_RISE: edge_hit = rise;
      TEC16_EDGE_FALL: edge_hit = fall;
      TEC16_EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction : edge_hit

  // Divider tap: fires once every 2**code cycles
  function automatic logic div_tick(input logic [`TEC_PRE_W-1:0] p,
                                    input logic [2:0] code);
    logic [`TEC_PRE_W:0] m;
    m = ({{`TEC_PRE_W{1'b0}}, 1'b1} << code) - {{`TEC_PRE_W{1'b0}}, 1'b1};
    div_tick = (p & m[`TEC_PRE_W-1:0]) == m[`TEC_PRE_W-1:0];
  endfunction : div_tick

  // Byte-lane merge of a bus write into a register image
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Registers
  tec16_ctl0_s ctl0_r;
  logic [7:0] ctl1_r;
  logic [7:0] ocfg_r;
  logic [7:0] ecfg_a_r;
  logic [7:0] ecfg_b_r;
  logic [15:0] ccr0_r;
  logic [15:0] ccr1_r;
  logic [15:0] buf0_r;
  logic [15:0] buf1_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic ovf_r;
  logic [`TEC_PRE_W-1:0] pre_r;
  logic running_r;
  logic started_r;
  logic tog0_r;
  logic tog1_r;
  tec16_aphase_s ap_r;

  // Pin synchronisers and filtered levels
  logic [2:0] in0_s;
  logic [2:0] in1_s;
  logic [2:0] sub_s;
  logic in0_f_r;
  logic in1_f_r;
  logic sub_f_r;

  // Address-phase acceptance and data-phase decode
  wire logic ap_take = hsel & htrans[1] & hready;
  wire logic [3:0] be_w;
  wire logic wr_phase = ap_r.valid & ap_r.write;
  wire logic wr_ctl0 = wr_phase & (ap_r.addr == `TEC_ADR_CTL0) & be_w[0];
  wire logic wr_ctl1 = wr_phase & (ap_r.addr == `TEC_ADR_CTL1) & be_w[0];
  wire logic wr_ocfg = wr_phase & (ap_r.addr == `TEC_ADR_OCFG) & be_w[0];
  wire logic wr_ecfga = wr_phase & (ap_r.addr == `TEC_ADR_ECFGA) & be_w[0];
  wire logic wr_ecfgb = wr_phase & (ap_r.addr == `TEC_ADR_ECFGB) & be_w[0];
  wire logic wr_ccr0 = wr_phase & (ap_r.addr == `TEC_ADR_CCR0);
  wire logic wr_ccr1 = wr_phase & (ap_r.addr == `TEC_ADR_CCR1);
  wire logic wr_stat = wr_phase & (ap_r.addr == `TEC_ADR_STAT) & be_w[0];

  // Byte enables from hsize and the low address bits
  assign be_w = (ap_r.size == `TEC_HSIZE_BYTE) ?
                  (4'h1 << ap_r.addr[1:0]) :
                (ap_r.size == `TEC_HSIZE_HALF) ?
                  (ap_r.addr[1] ? 4'hc : 4'h3) : 4'hf;

  // Control fields seen by the counting logic
  wire logic en = ctl0_r.en;
  wire tec16_mode_e mode = tec16_mode_e'(ctl1_r[2:0]);
  wire logic ext_src = (mode == TEC16_MD_EVENT) | ctl1_r[`TEC_CTL1_EEE];

  // Filtered edges of the three pins
  wire logic in0_new = (in0_s[1] == in0_s[2]) ? in0_s[2] : in0_f_r;
  wire logic in1_new = (in1_s[1] == in1_s[2]) ? in1_s[2] : in1_f_r;
  wire logic sub_new = (sub_s[1] == sub_s[2]) ? sub_s[2] : sub_f_r;
  wire logic in0_rise = in0_new & ~in0_f_r;
  wire logic in0_fall = ~in0_new & in0_f_r;
  wire logic in1_rise = in1_new & ~in1_f_r;
  wire logic in1_fall = ~in1_new & in1_f_r;
  wire logic sub_rise = sub_new & ~sub_f_r;

  // Per-pin qualified edges; input 0 has capture/trigger and event paths
  wire logic cap0_edge = edge_hit(ecfg_a_r[1:0], in0_rise, in0_fall);
  wire logic cap1_edge = edge_hit(ecfg_a_r[3:2], in1_rise, in1_fall);
  wire logic evt_edge = edge_hit(ecfg_b_r[1:0], in0_rise, in0_fall);

  // Count source: subclock only on odd channels and only with main clock
  wire logic use_sub = ODD_CHANNEL & (ctl0_r.cks == `TEC_CKS_SUB);
  wire logic int_tick = use_sub ? (sub_rise & ~main_clk_stopped)
                                : div_tick(pre_r, ctl0_r.cks);
  wire logic src_tick = ext_src ? evt_edge : int_tick;

  // Triggered modes start on an input edge or a software trigger write
  wire logic trig_mode = (mode == TEC16_MD_EXT_TRIG) |
                         (mode == TEC16_MD_ONE_SHOT);
  wire logic sw_trig = wr_ctl1 & hwdata[`TEC_CTL1_EST] & trig_mode;
  wire logic trigger = en & trig_mode & (cap0_edge | sw_trig);

  // Counting is gated off in triggered modes until a trigger arrives
  wire logic counting = en & (mode != TEC16_MD_PROHIBITED) &
                        (~trig_mode | running_r);
  wire logic step = counting & src_tick;
  wire logic cnt_inc_wrap = step & (cnt_r == `TEC_CNT_IDLE);
  wire logic [15:0] cnt_inc = cnt_r + `TEC_CNT_ONE;

  // Compare hits against the hidden buffers, at the count edge
  wire logic cmp_mode = mode != TEC16_MD_PULSE_WIDTH;
  wire logic hit0 = step & cmp_mode & (cnt_r == buf0_r);
  wire logic hit1 = step & cmp_mode & (cnt_r == buf1_r);
  wire logic clear_on_hit0 = hit0 & (mode != TEC16_MD_FREE_RUN);

  // Pulse width capture latches the count and restarts from zero
  wire logic pw_mode = en & (mode == TEC16_MD_PULSE_WIDTH);
  wire logic pw_cap0 = pw_mode & cap0_edge;
  wire logic pw_cap1 = pw_mode & cap1_edge;

  // Overflow only counts a wrap that follows an earlier count; the first
  // step leaves the idle all-ones value and is a start, not a wrap
  wire logic ovf_set = cnt_inc_wrap & started_r & ~trig_mode &
                       (mode != TEC16_MD_INTERVAL);

  // Next count value
  always_comb begin
    cnt_nxt = cnt_r;
    if (!en) begin
      cnt_nxt = `TEC_CNT_IDLE;
    end else if (pw_cap0 | pw_cap1) begin
      cnt_nxt = `TEC_CNT_ZERO;
    end else if (trigger) begin
      cnt_nxt = `TEC_CNT_ZERO;
    end else if (clear_on_hit0) begin
      cnt_nxt = `TEC_CNT_ZERO;
    end else if (step) begin
      cnt_nxt = cnt_inc;
    end
  end

  // Read data mux; the count reads zero while the channel is off
  wire logic [31:0] rd_mux =
    (haddr == `TEC_ADR_CTL0) ? {24'h000000, ctl0_r} :
    (haddr == `TEC_ADR_CTL1) ? {24'h000000, ctl1_r} :
    (haddr == `TEC_ADR_OCFG) ? {24'h000000, ocfg_r} :
    (haddr == `TEC_ADR_ECFGA) ? {24'h000000, ecfg_a_r} :
    (haddr == `TEC_ADR_ECFGB) ? {24'h000000, ecfg_b_r} :
    (haddr == `TEC_ADR_CCR0) ? {16'h0000, ccr0_r} :
    (haddr == `TEC_ADR_CCR1) ? {16'h0000, ccr1_r} :
    (haddr == `TEC_ADR_CNT) ?
      {16'h0000, en ? cnt_r : `TEC_CNT_ZERO} :
    (haddr == `TEC_ADR_STAT) ? {31'h00000000, ovf_r} :
    32'h00000000;

  // Bus slave: zero wait states, always OKAY, read data at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      ap_r <= '{valid: ap_take, write: hwrite, size: hsize, addr: haddr};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_take & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Control registers; rewriting the same value changes nothing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl0_r <= tec16_ctl0_s'(`TEC_RST_BYTE);
      ctl1_r <= `TEC_RST_BYTE;
      ocfg_r <= `TEC_RST_BYTE;
      ecfg_a_r <= `TEC_RST_BYTE;
      ecfg_b_r <= `TEC_RST_BYTE;
    end else begin
      if (wr_ctl0) begin
        ctl0_r <= tec16_ctl0_s'(hwdata[7:0] & `TEC_CTL0_MASK);
      end
      if (wr_ctl1) begin
        ctl1_r <= hwdata[7:0] & `TEC_CTL1_MASK;
      end
      if (wr_ocfg) begin
        ocfg_r <= hwdata[7:0] & `TEC_OCFG_MASK;
      end
      if (wr_ecfga) begin
        ecfg_a_r <= hwdata[7:0] & `TEC_ECFG_MASK;
      end
      if (wr_ecfgb) begin
        ecfg_b_r <= hwdata[7:0] & `TEC_ECFG_MASK;
      end
    end
  end

  // Capture/compare registers and their hidden compare buffers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ccr0_r <= `TEC_RST_WORD;
      ccr1_r <= `TEC_RST_WORD;
      buf0_r <= `TEC_RST_WORD;
      buf1_r <= `TEC_RST_WORD;
    end else begin
      if (pw_cap0) begin
        ccr0_r <= cnt_r;
      end else if (wr_ccr0) begin
        ccr0_r <= merge16(ccr0_r, hwdata, be_w);
        buf0_r <= merge16(ccr0_r, hwdata, be_w);
      end
      if (pw_cap1) begin
        ccr1_r <= cnt_r;
      end else if (wr_ccr1) begin
        ccr1_r <= merge16(ccr1_r, hwdata, be_w);
        buf1_r <= merge16(ccr1_r, hwdata, be_w);
      end
    end
  end

  // Three-stage pin synchronisers with agreement filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in0_s <= 3'h0;
      in1_s <= 3'h0;
      sub_s <= 3'h0;
      in0_f_r <= 1'b0;
      in1_f_r <= 1'b0;
      sub_f_r <= 1'b0;
    end else begin
      in0_s <= {in0_s[1:0], timer_input_0};
      in1_s <= {in1_s[1:0], timer_input_1};
      sub_s <= {sub_s[1:0], subclock_in};
      in0_f_r <= in0_new;
      in1_f_r <= in1_new;
      sub_f_r <= sub_new;
    end
  end

  // Prescaler runs only while enabled so every start has the same phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= '0;
    end else if (!en) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + {{(`TEC_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // Counter, run state for triggered modes, overflow flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= `TEC_CNT_IDLE;
      running_r <= 1'b0;
      started_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      started_r <= en & (started_r | step);
      if (!en) begin
        running_r <= 1'b0;
      end else if (trigger) begin
        running_r <= 1'b1;
      end else if (hit0 & (mode == TEC16_MD_ONE_SHOT)) begin
        running_r <= 1'b0; // One pulse, then wait for the next trigger
      end
      // Set wins over a software clear in the same cycle
      if (!en) begin
        ovf_r <= 1'b0;
      end else if (ovf_set) begin
        ovf_r <= 1'b1;
      end else if (wr_stat & ~hwdata[`TEC_STAT_OVF]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // Toggle state behind each output pin; cleared while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog0_r <= 1'b0;
      tog1_r <= 1'b0;
    end else if (!en) begin
      tog0_r <= 1'b0;
      tog1_r <= 1'b0;
    end else begin
      tog0_r <= tog0_r ^ hit0;
      tog1_r <= tog1_r ^ hit1;
    end
  end

  // Registered pins: level bit inverts, enable bit gates the toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_0 <= 1'b0;
      timer_output_1 <= 1'b0;
      match_irq_0 <= 1'b0;
      match_irq_1 <= 1'b0;
    end else begin
      timer_output_0 <= (ocfg_r[0] & en & tog0_r) ^ ocfg_r[1];
      timer_output_1 <= (ocfg_r[2] & en & tog1_r) ^ ocfg_r[3];
      match_irq_0 <= hit0;
      match_irq_1 <= hit1;
    end
  end

endmodule : tec16_timer

// ==== tb/tec16_far_model.sv ====
`timescale 1ns/1ns
module tec16_far_model (
  input wire logic hclk,
  input wire logic sub_run,
  output logic timer_input_0,
  output logic timer_input_1,
  output logic subclock_in
);
  logic [2:0] sub_cnt_r = 3'h0;
  initial begin
    timer_input_0 = 1'b0;
    timer_input_1 = 1'b0;
    subclock_in = 1'b0;
  end
  // Subclock only runs on request; parked low so no stray edge counts
  always @(posedge hclk) begin
    sub_cnt_r <= (sub_cnt_r == 3'h5) ? 3'h0 : sub_cnt_r + 3'h1;
    if (!sub_run) subclock_in <= 1'b0;
    else if (sub_cnt_r == 3'h5) subclock_in <= ~subclock_in;
  end
  // Pins toggle slowly enough for the three-stage input synchroniser
  task toggle_in0(input int n);
    repeat (n) begin
      repeat (8) @(posedge hclk);
      timer_input_0 <= ~timer_input_0;
      timer_input_1 <= ~timer_input_1;
    end
  endtask : toggle_in0
endmodule : tec16_far_model

// ==== tb/tec16_props.sv ====
`timescale 1ns/1ns
`include "tec16_consts.svh"
module tec16_props
  import tec16_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer_input_0,
  input wire logic timer_input_1,
  input wire logic subclock_in,
  input wire logic main_clk_stopped,
  input wire logic timer_output_0,
  input wire logic timer_output_1,
  input wire logic match_irq_0,
  input wire logic match_irq_1
);
  logic ap_wr_r;
  logic ap_rd_r;
  logic [31:0] ap_adr_r;
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [7:0] ocfg_r;
  logic [15:0] ccr0_r;
  logic [2:0] quiet_r;
  wire take = hsel && htrans[1] && hready;
  wire dwr = ap_wr_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of software writes; the quiet count restarts on any write
  // because a write may still be landing in the block's registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ap_wr_r, ap_rd_r, ap_adr_r} <= '0;
      {ctl0_r, ctl1_r, ocfg_r, ccr0_r, quiet_r} <= '0;
    end else begin
      ap_wr_r <= take && hwrite;
      ap_rd_r <= take && !hwrite;
      ap_adr_r <= haddr;
      if (dwr && ap_adr_r == `TEC_ADR_CTL0) ctl0_r <= hwdata[7:0];
      if (dwr && ap_adr_r == `TEC_ADR_CTL1) ctl1_r <= hwdata[7:0];
      if (dwr && ap_adr_r == `TEC_ADR_OCFG) ocfg_r <= hwdata[7:0];
      if (dwr && ap_adr_r == `TEC_ADR_CCR0) ccr0_r <= hwdata[15:0];
      if (ctl0_r[7] || dwr) quiet_r <= 3'h0;
      else if (quiet_r != 3'h4) quiet_r <= quiet_r + 3'h1;
    end
  end
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  a_ready_up: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low after reset");
  a_reset_quiet: assert property ($rose(hresetn) |->
    !timer_output_0 && !timer_output_1 && !match_irq_0 && !match_irq_1)
    else $error("outputs not cleared by reset");
  a_count_reads_zero: assert property (ap_rd_r &&
    ap_adr_r == `TEC_ADR_CNT && !ctl0_r[7] && quiet_r >= 3'h2
    |-> hrdata[15:0] == 16'h0000) else $error("count read nonzero");
  a_out_idle: assert property (quiet_r == 3'h4 |->
    timer_output_0 == ocfg_r[1] && timer_output_1 == ocfg_r[3])
    else $error("timer pins not at idle level while stopped");
  a_irq0_off: assert property (quiet_r == 3'h4 |-> !match_irq_0)
    else $error("match 0 pulse while stopped");
  a_irq1_off: assert property (quiet_r == 3'h4 |-> !match_irq_1)
    else $error("match 1 pulse while stopped");
  a_irq0_pulse: assert property (match_irq_0 && ccr0_r != 16'h0 &&
    ctl1_r[2:0] == 3'h0 && !ctl1_r[5] |=> !match_irq_0)
    else $error("match 0 held longer than one cycle");
endmodule : tec16_props

bind tec16_timer tec16_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_input_0(timer_input_0),
  .timer_input_1(timer_input_1), .subclock_in(subclock_in),
  .main_clk_stopped(main_clk_stopped), .timer_output_0(timer_output_0),
  .timer_output_1(timer_output_1), .match_irq_0(match_irq_0),
  .match_irq_1(match_irq_1));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "tec16_consts.svh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic main_clk_stopped = 1'b0;
  logic sub_run = 1'b0;
  logic [31:0] rd;
  logic [31:0] gap;
  wire [31:0] hrdata;
  wire hreadyout, hresp, timer_input_0, timer_input_1, subclock_in;
  wire timer_output_0, timer_output_1, match_irq_0, match_irq_1;
  wire [1:0] irqs = {match_irq_1, match_irq_0};
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [15:0] EV_EXP [4] = '{16'hffff, 16'h3, 16'h3, 16'h7};

  always #5 hclk = ~hclk;

  // Odd channel so that code 7 reaches the subclock path
  tec16_timer #(.ODD_CHANNEL(1'b1)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_input_0(timer_input_0),
    .timer_input_1(timer_input_1), .subclock_in(subclock_in),
    .main_clk_stopped(main_clk_stopped), .timer_output_0(timer_output_0),
    .timer_output_1(timer_output_1), .match_irq_0(match_irq_0),
    .match_irq_1(match_irq_1));

  tec16_far_model far (.hclk(hclk), .sub_run(sub_run),
    .timer_input_0(timer_input_0), .timer_input_1(timer_input_1),
    .subclock_in(subclock_in));

  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Free-running overflow wait dominates; ceiling leaves headroom
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single transfer: address phase, then data phase, each held to hready
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer

  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'h2);
  endtask : wr

  task rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 3'h2);
    chk(rd, exp);
  endtask : rdc

  // Cycles between two successive pulses of one match request
  task gap_of(input int w, output logic [31:0] g);
    int n;
    n = 0;
    g = 32'h0;
    @(posedge hclk);
    while (irqs[w] !== 1'b1 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    do begin
      @(posedge hclk);
      g++;
    end while (irqs[w] !== 1'b1 && g < 2000);
  endtask : gap_of

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`TEC_ADR_CTL0, 32'h0);
    rdc(`TEC_ADR_CNT, 32'h0);
    rdc(`TEC_ADR_CCR0, 32'h0);
    rdc(`TEC_ADR_CCR1, 32'h0);
    wr(32'h0ffff5fc, 32'h1);
    rdc(32'h0ffff5fc, 32'h0);
    // Every main-clock divider; select set together with enable
    wr(`TEC_ADR_CCR0, 32'h3);
    for (int k = 0; k < 7; k++) begin
      wr(`TEC_ADR_CTL0, 32'h0);
      wr(`TEC_ADR_CTL0, 32'h80 | k);
      wr(`TEC_ADR_CTL0, 32'h80 | k);
      gap_of(0, gap);
      chk(gap, 32'h4 << k);
    end
    // Both compare channels in one interval period, pin 0 toggling, pin 1 held inverted
    wr(`TEC_ADR_CTL0, 32'h0);
    wr(`TEC_ADR_CCR0, 32'h7);
    wr(`TEC_ADR_CCR1, 32'h2);
    wr(`TEC_ADR_OCFG, 32'h9);
    wr(`TEC_ADR_CTL0, 32'h80);
    gap_of(1, gap);
    chk(gap, 32'h8);
    gap_of(0, gap);
    chk(gap, 32'h8);
    xfer(1'b0, `TEC_ADR_CNT, 32'h0, 3'h2);
    chk({31'h0, rd[15:0] <= 16'h7}, 32'h1);
    wr(`TEC_ADR_CTL0, 32'h0);
    repeat (3) @(posedge hclk);
    chk({30'h0, timer_output_1, timer_output_0}, 32'h2);
    rdc(`TEC_ADR_CNT, 32'h0);
    // Subclock source, first with the main clock reported stopped
    wr(`TEC_ADR_CCR0, 32'h3);
    sub_run <= 1'b1;
    main_clk_stopped <= 1'b1;
    wr(`TEC_ADR_CTL0, 32'h87);
    repeat (200) @(posedge hclk);
    rdc(`TEC_ADR_CNT, 32'hffff);
    main_clk_stopped <= 1'b0;
    repeat (200) @(posedge hclk);
    xfer(1'b0, `TEC_ADR_CNT, 32'h0, 3'h2);
    chk({31'h0, rd[15:0] <= 16'h3}, 32'h1);
    sub_run <= 1'b0;
    // Event counting under each edge selection
    wr(`TEC_ADR_CTL0, 32'h0);
    wr(`TEC_ADR_CTL1, 32'h1);
    wr(`TEC_ADR_CCR0, 32'hffff);
    for (int e = 0; e < 4; e++) begin
      wr(`TEC_ADR_CTL0, 32'h0);
      wr(`TEC_ADR_ECFGB, e);
      wr(`TEC_ADR_CTL0, 32'h80);
      far.toggle_in0(8);
      repeat (8) @(posedge hclk);
      xfer(1'b0, `TEC_ADR_CNT, 32'h0, 3'h2);
      chk({16'h0, rd[15:0]}, {16'h0, EV_EXP[e]});
    end
    // One-shot waits at all ones for a software trigger, then one period
    wr(`TEC_ADR_CTL0, 32'h0);
    wr(`TEC_ADR_CTL1, 32'h3);
    wr(`TEC_ADR_CCR0, 32'h3);
    wr(`TEC_ADR_CTL0, 32'h80);
    repeat (20) @(posedge hclk);
    rdc(`TEC_ADR_CNT, 32'hffff);
    wr(`TEC_ADR_CTL1, 32'h43);
    rdc(`TEC_ADR_CTL1, 32'h3);
    repeat (20) @(posedge hclk);
    rdc(`TEC_ADR_CNT, 32'h0);
    // Pulse width: rising edges on input 0 come sixteen cycles apart
    wr(`TEC_ADR_CTL0, 32'h0);
    wr(`TEC_ADR_CTL1, 32'h6);
    wr(`TEC_ADR_ECFGA, 32'h1);
    wr(`TEC_ADR_CTL0, 32'h80);
    far.toggle_in0(4);
    repeat (8) @(posedge hclk);
    rdc(`TEC_ADR_CCR0, 32'hf);
    // Prohibited mode code never counts
    wr(`TEC_ADR_CTL0, 32'h0);
    wr(`TEC_ADR_CTL1, 32'h7);
    wr(`TEC_ADR_CTL0, 32'h80);
    repeat (20) @(posedge hclk);
    rdc(`TEC_ADR_CNT, 32'hffff);
    // Free-running wrap sets overflow; leaving all ones does not
    wr(`TEC_ADR_CTL0, 32'h0);
    wr(`TEC_ADR_CTL1, 32'h5);
    wr(`TEC_ADR_CTL0, 32'h80);
    rdc(`TEC_ADR_STAT, 32'h0);
    repeat (65540) @(posedge hclk);
    rdc(`TEC_ADR_STAT, 32'h1);
    wr(`TEC_ADR_CTL0, 32'h0);
    rdc(`TEC_ADR_STAT, 32'h0);
    // Reset in mid-run clears the enable bit and the control registers
    wr(`TEC_ADR_CTL0, 32'h80);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`TEC_ADR_CTL0, 32'h0);
    rdc(`TEC_ADR_CTL1, 32'h0);
    rdc(`TEC_ADR_CNT, 32'h0);
    finish_test();
  end
endmodule : testbench
